// ### lpc_pkg.sv
// Constants and types for the passive panel display controller
package lpc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [31:0] LPC_BASE      = 32'hFFFF1400;
    localparam logic [31:0] LPC_ORDER_ADR = 32'hFFFFA414;
    localparam int          LPC_NREG      = 21;
    localparam logic [7:0]  OFS_MODE      = 8'h00;
    localparam logic [7:0]  OFS_BC        = 8'h04;
    localparam logic [7:0]  OFS_CP1W      = 8'h08;
    localparam logic [7:0]  OFS_DUTY_LO   = 8'h0C;
    localparam logic [7:0]  OFS_DUTY_HI   = 8'h10;
    localparam logic [7:0]  OFS_SA1_B0    = 8'h14;
    localparam logic [7:0]  OFS_SA1_B1    = 8'h18;
    localparam logic [7:0]  OFS_SA1_B2    = 8'h1C;
    localparam logic [7:0]  OFS_SA1_B3    = 8'h20;
    localparam logic [7:0]  OFS_SA2_B0    = 8'h24;
    localparam logic [7:0]  OFS_SA2_B1    = 8'h28;
    localparam logic [7:0]  OFS_SA2_B2    = 8'h2C;
    localparam logic [7:0]  OFS_SA2_B3    = 8'h30;
    localparam logic [7:0]  OFS_VLC_LO    = 8'h34;
    localparam logic [7:0]  OFS_VLC_HI    = 8'h38;
    localparam logic [7:0]  OFS_VDLT      = 8'h3C;
    localparam logic [7:0]  OFS_SHADE1    = 8'h40;
    localparam logic [7:0]  OFS_SHADE2    = 8'h44;
    localparam logic [7:0]  OFS_CLKDIV    = 8'h48;
    localparam logic [7:0]  OFS_ACW_LO    = 8'h4C;
    localparam logic [7:0]  OFS_ACW_HI    = 8'h50;
    localparam logic [7:0]  REG_RST       = 8'h00;
    localparam logic [7:0]  ORDER_RST     = 8'h00;

    // ----------------------------------------
    // Mode and order register fields
    // ----------------------------------------
    localparam int MB_ACT  = 0;
    localparam int MB_AUX  = 1;
    localparam int MB_WIDE = 2;
    localparam int MB_GRAY = 3;
    localparam int MB_ORM  = 4;
    localparam int MB_DUAL = 5;
    localparam int MB_INV  = 6;
    localparam int MB_VEN  = 7;
    localparam int OB_REV  = 0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_SHIFT = 2'b11,
        ST_LATCH = 2'b10
    } lpc_state_type;

    typedef struct packed {
        logic [7:0] pixel_data_out;
        logic       pixel_shift_clock;
        logic       line_latch_pulse;
        logic       frame_marker;
        logic       ac_modulation;
        logic       panel_aux_pin;
    } lpc_panel_type;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } lpc_mreq_type;

endpackage : lpc_pkg

// ### lpc_top.sv
// Passive panel display controller with APB registers and memory fetch
`timescale 1ns/1ps
module lpc_top
    import lpc_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          pce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          mem_ack,
    input  wire logic [15:0]   mem_rdata,
    output lpc_pkg::lpc_mreq_type  mem_out,
    output lpc_pkg::lpc_panel_type panel_out
);
    import lpc_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [4:0] reg_idx(input logic [31:0] a);
        reg_idx = a[6:2];
    endfunction : reg_idx

    function automatic logic [15:0] to_pix(
        input logic [15:0] raw,
        input logic        gray,
        input logic [7:0]  smap,
        input logic        fph,
        input logic        invert_video
    );
        logic [15:0] s;
        logic [15:0] r;
        s = {raw[7:0], raw[15:8]};
        r = s;
        for (int i = 0; i < 16; i++)
        begin
            if (invert_video)
            begin
                r[i] = s[(i / 8) * 8 + 7 - (i % 8)];
            end
        end
        to_pix = r;
        if (gray)
        begin
            to_pix = 16'h0000;
            for (int k = 0; k < 8; k++)
            begin
                to_pix[15-k] = smap[{r[15-2*k], r[14-2*k], fph}];
            end
        end
    endfunction : to_pix

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0]  regs_q [LPC_NREG];
    logic [7:0]  regs_d [LPC_NREG];
    logic [7:0]  order_q;
    logic [7:0]  order_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        sel_lcd;
    logic        sel_ord;
    logic        done;

    assign sel_lcd = (paddr[31:8] == LPC_BASE[31:8]) &&
                     (paddr[7:0] <= OFS_ACW_HI) &&
                     (paddr[1:0] == 2'b00);
    assign sel_ord = (paddr == LPC_ORDER_ADR);
    assign done    = psel && penable && pready_q;

    always_comb
    begin
        regs_d    = regs_q;
        order_d   = order_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        pready_d  = 1'b0;
        if (psel && penable && !pready_q)
        begin
            pready_d  = 1'b1;
            pslverr_d = !(sel_lcd || sel_ord);
            // Mode and geometry registers read back as zero
            prdata_d  = sel_ord ? {24'h000000, order_q} : 32'h00000000;
        end
        if (done && pwrite && pstrb[0] && !pslverr_q)
        begin
            if (sel_lcd)
            begin
                regs_d[reg_idx(paddr)] = pwdata[7:0];
            end
            if (sel_ord)
            begin
                order_d = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < LPC_NREG; i++)
            begin
                regs_q[i] <= REG_RST;
            end
            order_q   <= ORDER_RST;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (pce)
        begin
            regs_q    <= regs_d;
            order_q   <= order_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ----------------------------------------
    // Joined fields and mode decode
    // ----------------------------------------
    logic [7:0]  mode;
    logic [9:0]  duty;
    logic [9:0]  vlc;
    logic [9:0]  acw;
    logic [31:0] sadr1;
    logic [31:0] sadr2;
    logic [31:0] stride;
    logic        act;
    logic        dual;
    logic        orm;
    logic        gray;
    logic        wide;
    logic        lower;
    logic        use_a;
    logic        use_b;

    assign mode  = regs_q[reg_idx({24'h0, OFS_MODE})];
    assign duty  = {regs_q[reg_idx({24'h0, OFS_DUTY_HI})][1:0],
                    regs_q[reg_idx({24'h0, OFS_DUTY_LO})]};
    assign vlc   = {regs_q[reg_idx({24'h0, OFS_VLC_HI})][1:0],
                    regs_q[reg_idx({24'h0, OFS_VLC_LO})]};
    assign acw   = {regs_q[reg_idx({24'h0, OFS_ACW_HI})][1:0],
                    regs_q[reg_idx({24'h0, OFS_ACW_LO})]};
    assign sadr1 = {regs_q[reg_idx({24'h0, OFS_SA1_B3})],
                    regs_q[reg_idx({24'h0, OFS_SA1_B2})],
                    regs_q[reg_idx({24'h0, OFS_SA1_B1})],
                    regs_q[reg_idx({24'h0, OFS_SA1_B0})]};
    assign sadr2 = {regs_q[reg_idx({24'h0, OFS_SA2_B3})],
                    regs_q[reg_idx({24'h0, OFS_SA2_B2})],
                    regs_q[reg_idx({24'h0, OFS_SA2_B1})],
                    regs_q[reg_idx({24'h0, OFS_SA2_B0})]};
    // Bytes per line is count plus one, then the virtual skip
    assign stride = {24'h0, regs_q[reg_idx({24'h0, OFS_BC})]} + 32'h1 +
                    {24'h0, regs_q[reg_idx({24'h0, OFS_VDLT})]};
    assign act   = mode[MB_ACT];
    assign dual  = mode[MB_DUAL];
    assign orm   = mode[MB_ORM] && !dual;
    assign gray  = mode[MB_GRAY];
    assign wide  = mode[MB_WIDE] && !gray && !dual;

    // ----------------------------------------
    // Display engine
    // ----------------------------------------
    lpc_state_type st_q, st_d;
    logic [7:0]    div_q, div_d;
    logic [10:0]   line_q, line_d;
    logic [7:0]    hw_q, hw_d;
    logic [1:0]    xf_q, xf_d;
    logic [15:0]   pa_q, pa_d;
    logic [15:0]   pb_q, pb_d;
    logic [31:0]   la_q, la_d;
    logic [31:0]   lb_q, lb_d;
    logic [31:0]   aa_q, aa_d;
    logic [31:0]   ab_q, ab_d;
    logic          fsel_q, fsel_d;
    logic          ph_q, ph_d;
    logic          fph_q, fph_d;
    logic [8:0]    wc_q, wc_d;
    logic [9:0]    acc_q, acc_d;
    lpc_panel_type panel_q, panel_d;
    lpc_mreq_type  mem_q, mem_d;
    logic          tick;
    logic [15:0]   src;
    logic [7:0]    vd;
    logic [15:0]   conv;

    // Split point compares the line against the upper screen count
    // A line count at or above duty keeps the whole panel on one screen
    assign lower = !dual && !orm && (vlc < duty) &&
                   ({1'b0, vlc} <= line_q);
    assign use_a = dual || orm || !lower;
    assign use_b = dual || orm || lower;
    // Divider is read live, so it must not move while running
    assign tick  = (div_q == regs_q[reg_idx({24'h0, OFS_CLKDIV})]);
    assign src   = orm ? (pa_q | pb_q) : (lower ? pb_q : pa_q);
    assign conv  = to_pix(mem_rdata, gray,
                          fsel_q ? regs_q[reg_idx({24'h0, OFS_SHADE2})]
                                 : regs_q[reg_idx({24'h0, OFS_SHADE1})],
                          fph_q, order_q[OB_REV]);

    always_comb
    begin
        if (dual)
        begin
            vd = {pb_q[15:12], pa_q[15:12]};
        end
        else if (wide)
        begin
            vd = src[15:8];
        end
        else
        begin
            vd = {4'h0, src[15:12]};
        end
        if (!mode[MB_VEN])
        begin
            vd = mode[MB_INV] ? 8'hFF : 8'h00;
        end
    end

    always_comb
    begin
        st_d    = st_q;
        div_d   = tick ? 8'h00 : div_q + 8'h01;
        line_d  = line_q;
        hw_d    = hw_q;
        xf_d    = xf_q;
        pa_d    = pa_q;
        pb_d    = pb_q;
        la_d    = la_q;
        lb_d    = lb_q;
        aa_d    = aa_q;
        ab_d    = ab_q;
        fsel_d  = fsel_q;
        ph_d    = ph_q;
        fph_d   = fph_q;
        wc_d    = wc_q;
        acc_d   = acc_q;
        panel_d = panel_q;
        mem_d   = mem_q;
        panel_d.panel_aux_pin = mode[MB_AUX];
        unique case (st_q)
            ST_IDLE:
            begin
                div_d  = 8'h00;
                line_d = 11'h000;
                la_d   = sadr1;
                lb_d   = sadr2;
                aa_d   = sadr1;
                ab_d   = sadr2;
                hw_d   = {1'b0, regs_q[reg_idx({24'h0, OFS_BC})][7:1]};
                fsel_d = !use_a;
                st_d   = ST_FETCH;
            end
            ST_FETCH:
            begin
                // Stalls the panel but never the processor
                if (!mem_q.req)
                begin
                    mem_d.req  = 1'b1;
                    mem_d.addr = fsel_q ? ab_q : aa_q;
                end
                else if (mem_ack)
                begin
                    mem_d.req = 1'b0;
                    if (fsel_q)
                    begin
                        pb_d = conv;
                        ab_d = ab_q + 32'h2;
                    end
                    else
                    begin
                        pa_d = conv;
                        aa_d = aa_q + 32'h2;
                    end
                    if (!fsel_q && use_b)
                    begin
                        fsel_d = 1'b1;
                    end
                    else
                    begin
                        xf_d = (wide || gray) ? 2'd1 : 2'd3;
                        ph_d = 1'b0;
                        st_d = ST_SHIFT;
                    end
                end
            end
            ST_SHIFT:
            begin
                if (tick && !ph_q)
                begin
                    panel_d.pixel_data_out    = vd;
                    panel_d.pixel_shift_clock = 1'b1;
                    ph_d = 1'b1;
                end
                else if (tick)
                begin
                    panel_d.pixel_shift_clock = 1'b0;
                    ph_d = 1'b0;
                    pa_d = wide ? {pa_q[7:0], 8'h00}
                                : {pa_q[11:0], 4'h0};
                    pb_d = {pb_q[11:0], 4'h0};
                    if (xf_q != 2'd0)
                    begin
                        xf_d = xf_q - 2'd1;
                    end
                    else if (hw_q != 8'h00)
                    begin
                        hw_d   = hw_q - 8'h01;
                        fsel_d = !use_a;
                        st_d   = ST_FETCH;
                    end
                    else
                    begin
                        panel_d.line_latch_pulse = 1'b1;
                        panel_d.frame_marker = (line_q == 11'h000);
                        wc_d = 9'h000;
                        st_d = ST_LATCH;
                    end
                end
            end
            ST_LATCH:
            begin
                if (tick)
                begin
                    wc_d = wc_q + 9'h001;
                end
                if (tick && wc_q == ({regs_q[reg_idx({24'h0,
                    OFS_CP1W})], 1'b0} - 9'h001))
                begin
                    panel_d.line_latch_pulse = 1'b0;
                    if (acc_q == acw)
                    begin
                        acc_d = 10'h000;
                        panel_d.ac_modulation =
                            !panel_q.ac_modulation;
                    end
                    else
                    begin
                        acc_d = acc_q + 10'h001;
                    end
                    if (line_q[9:0] == duty)
                    begin
                        // Frame wraps at duty plus one lines
                        line_d = 11'h000;
                        fph_d  = !fph_q;
                        la_d   = sadr1;
                        lb_d   = sadr2;
                    end
                    else
                    begin
                        line_d = line_q + 11'h001;
                        la_d   = use_a ? la_q + stride : la_q;
                        lb_d   = use_b ? lb_q + stride : lb_q;
                    end
                    aa_d   = la_d;
                    ab_d   = lb_d;
                    hw_d   = {1'b0,
                              regs_q[reg_idx({24'h0, OFS_BC})][7:1]};
                    fsel_d = 1'b0;
                    st_d   = ST_FETCH;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
        if (st_d == ST_FETCH && st_q == ST_LATCH)
        begin
            fsel_d = !(dual || orm || !(!dual && !orm && (vlc < duty) &&
                       ({1'b0, vlc} <= line_d)));
        end
        if (!act)
        begin
            st_d    = ST_IDLE;
            panel_d = '0;
            mem_d   = '0;
            acc_d   = 10'h000;
            fph_d   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q    <= ST_IDLE;
            div_q   <= 8'h00;
            line_q  <= 11'h000;
            hw_q    <= 8'h00;
            xf_q    <= 2'd0;
            pa_q    <= 16'h0000;
            pb_q    <= 16'h0000;
            la_q    <= 32'h00000000;
            lb_q    <= 32'h00000000;
            aa_q    <= 32'h00000000;
            ab_q    <= 32'h00000000;
            fsel_q  <= 1'b0;
            ph_q    <= 1'b0;
            fph_q   <= 1'b0;
            wc_q    <= 9'h000;
            acc_q   <= 10'h000;
            panel_q <= '0;
            mem_q   <= '0;
        end
        else if (pce)
        begin
            st_q    <= st_d;
            div_q   <= div_d;
            line_q  <= line_d;
            hw_q    <= hw_d;
            xf_q    <= xf_d;
            pa_q    <= pa_d;
            pb_q    <= pb_d;
            la_q    <= la_d;
            lb_q    <= lb_d;
            aa_q    <= aa_d;
            ab_q    <= ab_d;
            fsel_q  <= fsel_d;
            ph_q    <= ph_d;
            fph_q   <= fph_d;
            wc_q    <= wc_d;
            acc_q   <= acc_d;
            panel_q <= panel_d;
            mem_q   <= mem_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign mem_out   = mem_q;
    assign panel_out = panel_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_ready: assert property (
        psel && penable && !pready_q && pce |=> pready_q)
        else $error("apb access not answered");
    a_aux_pin: assert property (
        pce && act |=> panel_q.panel_aux_pin == $past(mode[MB_AUX]))
        else $error("aux pin not following mode");
    a_idle_quiet: assert property (
        pce && !act |=> panel_q == '0 && !mem_q.req)
        else $error("inactive controller drives outputs");
    a_blank_zero: assert property (
        $rose(panel_q.pixel_shift_clock) && !$past(mode[MB_VEN]) &&
        !$past(mode[MB_INV]) |-> panel_q.pixel_data_out == 8'h00)
        else $error("blanked data not zero");
    a_blank_ones: assert property (
        $rose(panel_q.pixel_shift_clock) && !$past(mode[MB_VEN]) &&
        $past(mode[MB_INV]) |-> panel_q.pixel_data_out == 8'hFF)
        else $error("inverted blank not ones");
    a_data_stable: assert property (
        $fell(panel_q.pixel_shift_clock) && $past(act)
        |-> $stable(panel_q.pixel_data_out))
        else $error("data moved at shift fall");
    a_latch_after: assert property (
        $rose(panel_q.line_latch_pulse) |-> hw_q == 8'h00 && xf_q == 2'd0)
        else $error("line pulse before line done");
    a_frame_valid: assert property (
        $fell(panel_q.line_latch_pulse) && $past(act)
        |-> panel_q.frame_marker == ($past(line_q) == 11'h000))
        else $error("frame marker wrong at line fall");
    a_ac_edge: assert property (
        $changed(panel_q.ac_modulation) && $past(act)
        |-> $fell(panel_q.line_latch_pulse))
        else $error("ac toggled off line boundary");
    a_fetch_on: assert property (
        st_q == ST_FETCH && !mem_q.req && pce && act |=> mem_q.req)
        else $error("fetch request not raised");

endmodule : lpc_top

// ### lpc_panel_model.sv
// Panel column and row driver model that watches the controller outputs
`timescale 1ns/1ps
module lpc_panel_model
    import lpc_pkg::*;
(
    input  wire logic              pclk,
    input  lpc_pkg::lpc_panel_type pin,
    output logic [7:0]             first_q,
    output int                     words_q,
    output int                     lw_q,
    output int                     lines_q,
    output int                     frames_q,
    output int                     flips_q,
    output int                     bad_q
);
    lpc_panel_type p_q;
    logic [7:0]    hold_q;
    logic          shift_fall;

    // Last word of a line falls in the same sample as the line pulse rise
    assign shift_fall = !pin.pixel_shift_clock && p_q.pixel_shift_clock;

    // Sampled on the system clock, as the panel only sees slow edges
    always @(posedge pclk)
    begin
        p_q <= pin;
        if (pin.pixel_shift_clock && !p_q.pixel_shift_clock)
            hold_q <= pin.pixel_data_out;
        if (shift_fall)
        begin
            if (words_q == 0)
                first_q <= p_q.pixel_data_out;
            if (p_q.pixel_data_out !== hold_q)
                bad_q <= bad_q + 1;
            words_q <= words_q + 1;
        end
        if (pin.line_latch_pulse && !p_q.line_latch_pulse)
        begin
            lw_q    <= words_q + (shift_fall ? 1 : 0);
            words_q <= 0;
        end
        if (!pin.line_latch_pulse && p_q.line_latch_pulse)
        begin
            lines_q <= lines_q + 1;
            if (p_q.frame_marker)
                frames_q <= frames_q + 1;
        end
        if (pin.ac_modulation !== p_q.ac_modulation)
            flips_q <= flips_q + 1;
    end
endmodule : lpc_panel_model

// ### lpc_top_test.sv
// Self-checking bench for the passive panel display controller
`timescale 1ns/1ps
module lpc_top_test;
    import lpc_pkg::*;
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic          pwrite = 0, mem_ack = 0, pready, pslverr, er;
    logic [31:0]   paddr = 0, pwdata = 0, prdata, rd;
    logic [15:0]   mem_rdata = 0;
    logic [7:0]    first;
    lpc_mreq_type  mem_out;
    lpc_panel_type panel_out;
    int            words, lw, lines, frames, flips, bad;
    int            error_cnt = 0, checks_done = 0;
    int            dly = 0, wcnt = 0, fetches = 0;

    always #10 pclk = ~pclk;

    lpc_top lpc_top_i (.pclk(pclk), .presetn(presetn), .pce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_out(mem_out), .panel_out(panel_out));
    lpc_panel_model lpc_panel_model_i (.pclk(pclk), .pin(panel_out),
        .first_q(first), .words_q(words), .lw_q(lw), .lines_q(lines),
        .frames_q(frames), .flips_q(flips), .bad_q(bad));

    // Memory answers after dly cycles; released data is inverted
    always @(posedge pclk)
    begin
        if (mem_ack)
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem_out.req === 1'b1)
        begin
            if (wcnt >= dly)
            begin
                mem_ack   <= 1'b1;
                wcnt      <= 0;
                fetches   <= fetches + 1;
                mem_rdata <= |mem_out.addr[30:29] ? 16'h9696 : 16'h5AC3;
            end
            else
                wcnt <= wcnt + 1;
        end
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] ofs, d);
        apb(1'b1, LPC_BASE + {24'h0, ofs}, d);
    endtask : wr

    // Bounded wait for n line pulse falls
    task run(input int n);
        int t, k;
        t = lines + n;
        k = 0;
        while (lines < t && k < 4000) begin @(posedge pclk); k++; end
        repeat (3) @(posedge pclk);
    endtask : run

    task t_regs;
        chk("idle", {19'h0, panel_out}, 32'h0);
        apb(1'b0, LPC_ORDER_ADR, 8'h00);
        chk("order", rd, 32'h0);
        apb(1'b1, LPC_ORDER_ADR, 8'h01);
        apb(1'b0, LPC_ORDER_ADR, 8'h00);
        chk("order", rd, 32'h1);
        apb(1'b1, LPC_ORDER_ADR, 8'h00);
        wr(OFS_CP1W, 8'h01);
        apb(1'b0, LPC_BASE + {24'h0, OFS_CP1W}, 8'h00);
        chk("wo", rd, 32'h0);
        apb(1'b0, LPC_BASE + 32'h54, 8'h00);
        chk("unmapped", {31'h0, er}, 32'h1);
    endtask : t_regs

    task t_run;
        int f0, a0;
        wr(OFS_BC, 8'h03);
        wr(OFS_CP1W, 8'h01);
        wr(OFS_DUTY_LO, 8'h02);
        wr(OFS_VLC_LO, 8'h03);
        wr(OFS_SA2_B3, 8'h40);
        wr(OFS_ACW_LO, 8'h01);
        wr(OFS_SHADE1, 8'hF0);
        wr(OFS_CLKDIV, 8'h01);
        wr(OFS_MODE, 8'h83);
        run(2);
        chk("aux", {31'h0, panel_out.panel_aux_pin}, 32'h1);
        chk("first", {28'h0, first[3:0]}, 32'hC);
        chk("words", lw, 8);
        chk("hold", bad, 0);
        dly = 3;
        f0 = frames;
        a0 = flips;
        run(6);
        chk("frames", frames - f0, 2);
        chk("acflips", flips - a0, 3);
        dly = 0;
    endtask : t_run

    task t_modes;
        logic [7:0] mt [6] = '{8'h85, 8'h8D, 8'hA5, 8'h91, 8'h01, 8'h41};
        logic [7:0] mk [6] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
        logic [7:0] ex [6] = '{8'hC3, 8'h09, 8'h9C, 8'h0D, 8'h00, 8'hFF};
        int         nw [6] = '{4, 4, 8, 8, 8, 8};
        int         f;
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_MODE, mt[i]);
            run(2);
            chk("words", lw, nw[i]);
            chk("first", {24'h0, first & mk[i]}, {24'h0, ex[i]});
        end
        f = fetches;
        run(1);
        chk("fetch", {31'h0, fetches > f}, 32'h1);
        wr(OFS_VLC_LO, 8'h00);
        wr(OFS_MODE, 8'h81);
        run(2);
        chk("lower", {28'h0, first[3:0]}, 32'h9);
        apb(1'b1, LPC_ORDER_ADR, 8'h01);
        run(2);
        chk("reversed", {28'h0, first[3:0]}, 32'h6);
        apb(1'b1, LPC_ORDER_ADR, 8'h00);
        wr(OFS_VLC_LO, 8'h02);
        run(1);
        for (int i = 0; i < 3; i++)
        begin
            run(1);
            chk("one screen", {28'h0, first[3:0]}, 32'hC);
        end
        wr(OFS_MODE, 8'h00);
        repeat (5) @(posedge pclk);
        chk("off", {18'h0, mem_out.req, panel_out}, 32'h0);
    endtask : t_modes

    task results;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Whole run needs well under this span; reaching it means a hang
    initial
    begin
        #400000;
        error_cnt++;
        results;
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_run;
        t_modes;
        results;
    end
endmodule : lpc_top_test
